// ==== include/sdcd_map.svh ====
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH

`define SDCD_AW 20
`define SDCD_BW 4
`define SDCD_NB 16
`define SDCD_DW 18
`define SDCD_MW 2
`define SDCD_LW 9
`define SDCD_RW 4

`define SDCD_MR_RST 20'h00000
`define SDCD_SEL_ZERO 2'h0
`define SDCD_SEL_ONE 2'h1
`define SDCD_SEL_TWO 2'h2

`define SDCD_BL_LO 8
`define SDCD_BL_HI 9
`define SDCD_WM_LO 3
`define SDCD_WM_HI 4
`define SDCD_WM_SINGLE 2'h0
`define SDCD_WM_DUAL 2'h1
`define SDCD_WM_QUAD 2'h2
`define SDCD_RF_BIT 5

`define SDCD_CLK_NS 20
`define SDCD_GAP_NS 240
`define SDCD_GAP_CYC ((`SDCD_GAP_NS + `SDCD_CLK_NS - 1) / `SDCD_CLK_NS)
`define SDCD_TAIL 2
`define SDCD_BEATS_BASE 4'h2

`endif

// ==== include/sdcd_pkg.sv ====
package sdcd_pkg;
  typedef enum logic [2:0] {
    idle_cmd     = 3'h0,
    mode_set_cmd = 3'h1,
    read_cmd     = 3'h2,
    write_cmd    = 3'h3,
    refresh_cmd  = 3'h4
  } sdcd_cmd_t;

  typedef enum logic [1:0] {
    burst_none  = 2'h0,
    burst_read  = 2'h1,
    burst_write = 2'h2
  } sdcd_burst_t;
endpackage : sdcd_pkg

// ==== include/sdcd_if.sv ====
`include "sdcd_map.svh"

interface sdcd_if;
  logic               cs_n;
  logic               we_n;
  logic               ref_n;
  logic [`SDCD_AW-1:0] addr;
  logic [`SDCD_BW-1:0] ba;
  logic [`SDCD_MW-1:0] byte_write_mask;
  logic [`SDCD_DW-1:0] dq_host_o;
  logic               dq_host_oe;
  logic [`SDCD_DW-1:0] dq_dev_o;
  logic               dq_dev_oe;
  logic [`SDCD_DW-1:0] dq;

  // device wins a clash; an undriven bus reads as zero
  assign dq = dq_dev_oe ? dq_dev_o : (dq_host_oe ? dq_host_o : '0);

  modport dev (
    input  cs_n, we_n, ref_n, addr, ba, byte_write_mask, dq,
    output dq_dev_o, dq_dev_oe
  );
  modport host (
    output cs_n, we_n, ref_n, addr, ba, byte_write_mask, dq_host_o, dq_host_oe,
    input  dq, dq_dev_oe
  );
endinterface : sdcd_if

// ==== core/sdcd_cmd_decode.sv ====
module sdcd_cmd_decode (
  input  wire logic          cs_n,  // chip select, low active
  input  wire logic          we_n,  // write enable, low active
  input  wire logic          ref_n, // refresh strobe, low active
  output sdcd_pkg::sdcd_cmd_t cmd    // decoded command
);
  import sdcd_pkg::*;

  always_comb begin
    if (cs_n) begin
      cmd = idle_cmd;
    end else begin
      case ({we_n, ref_n})
        2'h0:    cmd = mode_set_cmd;
        2'h3:    cmd = read_cmd;
        2'h1:    cmd = write_cmd;
        2'h2:    cmd = refresh_cmd;
        default: cmd = idle_cmd;
      endcase
    end
  end
endmodule : sdcd_cmd_decode

// ==== core/sdcd_device.sv ====
// Functional notes
// - pins sampled, commands decoded on rising edge only
// - decode chip select, write enable, refresh strobe
// - idle command starts nothing, bursts run on
// - mode set captures address and bank lines
// - low bank bits pick mode register zero-two
// - mode registers hold until rewritten or reset
// - controller sets modes only when all idle
// - controller waits mode set gap after mode set
// - read bursts from bank at given address
// - write mode field picks one, two, four banks
// - masked-high lanes leave array untouched
// - refresh single bank or up to four banks (device takes any mask of the 16)
// - refresh uses bank lines or address lines
// - controller issues one refresh per refresh
// - used address width follows burst length
`include "sdcd_map.svh"

module sdcd_device (
  input  wire logic                CLK,           // command clock, 50 MHz
  input  wire logic                RSTN,          // async reset, low active
  sdcd_if.dev                      LNK,           // pins from the controller
  output logic [`SDCD_AW-1:0]      MODE_ZERO,     // mode register zero
  output logic [`SDCD_AW-1:0]      MODE_ONE,      // mode register one
  output logic [`SDCD_AW-1:0]      MODE_TWO,      // mode register two
  output logic [`SDCD_BW-1:0]      MODE_SEL,      // bank lines of last mode set
  output logic                     BUSY,          // burst in progress
  output logic [`SDCD_AW-1:0]      ADDR_USED,     // masked address of last burst
  output logic [`SDCD_NB-1:0]      WR_BANKS,      // banks of last write
  output logic [`SDCD_NB-1:0]      REFRESH_BANKS, // banks refreshed, one cycle
  output sdcd_pkg::sdcd_cmd_t      LAST_CMD       // last non-idle command
);
  import sdcd_pkg::*;

  sdcd_cmd_t             cmd;
  sdcd_burst_t           burst;
  logic [1:0]            burst_code;
  logic [1:0]            wr_mode;
  logic [3:0]            beats;
  logic [3:0]            beat;
  logic [`SDCD_AW-1:0]   addr_mask;
  logic [`SDCD_AW-1:0]   masked_addr;
  logic [`SDCD_RW-1:0]   base;
  logic [`SDCD_RW-1:0]   row;
  logic [`SDCD_BW-1:0]   rd_bank;
  logic [`SDCD_NB-1:0]   wr_hit;
  logic [`SDCD_DW-1:0]   rd_word [`SDCD_NB];

  // pins come from logic on the same clock, so no synchroniser
  sdcd_cmd_decode u_decode (
    .cs_n  (LNK.cs_n),
    .we_n  (LNK.we_n),
    .ref_n (LNK.ref_n),
    .cmd   (cmd)
  );

  assign burst_code  = MODE_ONE[`SDCD_BL_HI:`SDCD_BL_LO];
  assign wr_mode     = MODE_TWO[`SDCD_WM_HI:`SDCD_WM_LO];
  assign beats       = `SDCD_BEATS_BASE << burst_code;
  // longer bursts need fewer address lines: top bits dropped
  assign addr_mask   = {`SDCD_AW{1'b1}} >> burst_code;
  assign masked_addr = LNK.addr & addr_mask;
  assign row         = base + beat[`SDCD_RW-1:0];

  // burst sequencing; a busy burst ignores new read/write commands
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      burst     <= burst_none;
      beat      <= 4'h0;
      base      <= '0;
      rd_bank   <= '0;
      BUSY      <= 1'b0;
      ADDR_USED <= '0;
      WR_BANKS  <= '0;
    end else if (burst != burst_none) begin
      beat <= beat + 4'h1;
      if (beat == beats - 4'h1) begin
        burst <= burst_none;
        BUSY  <= 1'b0;
      end
    end else begin
      case (cmd)
        read_cmd: begin
          burst     <= burst_read;
          beat      <= 4'h0;
          base      <= masked_addr[`SDCD_RW-1:0];
          rd_bank   <= LNK.ba;
          BUSY      <= 1'b1;
          ADDR_USED <= masked_addr;
        end
        write_cmd: begin
          burst     <= burst_write;
          beat      <= 4'h0;
          base      <= masked_addr[`SDCD_RW-1:0];
          BUSY      <= 1'b1;
          ADDR_USED <= masked_addr;
          WR_BANKS  <= wr_hit;
        end
        default: begin
        end
      endcase
    end
  end

  // one entry per bank: its array, write lanes and read port
  genvar g;
  generate
    for (g = 0; g < `SDCD_NB; g++) begin : g_bank
      localparam logic [`SDCD_BW-1:0] BID = `SDCD_BW'(g);
      logic [`SDCD_DW-1:0] mem [2**`SDCD_RW];

      always_comb begin
        case (wr_mode)
          `SDCD_WM_QUAD: wr_hit[g] = (BID[1:0] == LNK.ba[1:0]);
          `SDCD_WM_DUAL: wr_hit[g] = (BID[2:0] == LNK.ba[2:0]);
          default:       wr_hit[g] = (BID == LNK.ba);
        endcase
      end

      always_ff @(posedge CLK) begin
        if (burst == burst_write && WR_BANKS[g]) begin
          for (int l = 0; l < `SDCD_MW; l++) begin
            if (!LNK.byte_write_mask[l]) begin
              mem[row][l*`SDCD_LW +: `SDCD_LW] <= LNK.dq[l*`SDCD_LW +: `SDCD_LW];
            end
          end
        end
      end

      assign rd_word[g] = mem[row];
    end
  endgenerate

  // read data leaves one edge after each beat is addressed
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK.dq_dev_o  <= '0;
      LNK.dq_dev_oe <= 1'b0;
    end else begin
      LNK.dq_dev_oe <= (burst == burst_read);
      LNK.dq_dev_o  <= (burst == burst_read) ? rd_word[rd_bank] : '0;
    end
  end

  // mode registers; writes rely on the controller keeping all banks idle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MODE_ZERO <= `SDCD_MR_RST;
      MODE_ONE  <= `SDCD_MR_RST;
      MODE_TWO  <= `SDCD_MR_RST;
      MODE_SEL  <= '0;
    end else if (cmd == mode_set_cmd) begin
      MODE_SEL <= LNK.ba;
      case (LNK.ba[1:0])
        `SDCD_SEL_ZERO: MODE_ZERO <= LNK.addr;
        `SDCD_SEL_ONE:  MODE_ONE  <= LNK.addr;
        `SDCD_SEL_TWO:  MODE_TWO  <= LNK.addr;
        default: begin
        end
      endcase
    end
  end

  // refresh is a one-shot; nothing repeats without a new command
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      REFRESH_BANKS <= '0;
    end else if (cmd != refresh_cmd) begin
      REFRESH_BANKS <= '0;
    end else if (MODE_TWO[`SDCD_RF_BIT]) begin
      // bank mask taken as given; at most four bits is the controller's duty
      REFRESH_BANKS <= LNK.addr[`SDCD_NB-1:0];
    end else begin
      REFRESH_BANKS <= {{(`SDCD_NB-1){1'b0}}, 1'b1} << LNK.ba;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LAST_CMD <= idle_cmd;
    end else if (cmd != idle_cmd) begin
      LAST_CMD <= cmd;
    end
  end
endmodule : sdcd_device

// ==== core/sdcd_host.sv ====
`include "sdcd_map.svh"

module sdcd_host (
  input  wire logic                CLK,        // command clock, 50 MHz
  input  wire logic                RSTN,       // async reset, low active
  sdcd_if.host                     LNK,        // pins to the device
  input  wire logic                REQ_VALID,  // request present
  input  sdcd_pkg::sdcd_cmd_t      REQ_CMD,    // command to issue
  input  wire logic [`SDCD_AW-1:0] REQ_ADDR,   // address or opcode
  input  wire logic [`SDCD_BW-1:0] REQ_BA,     // bank lines
  output logic                     REQ_READY,  // request can be taken this edge
  input  wire logic [1:0]          BURST_CODE, // mirror of programmed burst field
  input  wire logic [`SDCD_DW-1:0] WR_DATA,    // write beat data
  input  wire logic [`SDCD_MW-1:0] WR_MASK,    // write beat lane mask
  output logic                     WR_TAKE,    // write beat taken this edge
  output logic [`SDCD_DW-1:0]      RD_DATA,    // read beat data
  output logic                     RD_VALID    // read beat valid
);
  import sdcd_pkg::*;

  localparam logic [7:0] GAP_CYC = 8'(`SDCD_GAP_CYC);
  localparam logic [7:0] TAIL    = 8'(`SDCD_TAIL);

  logic [7:0] gap;
  logic [3:0] beats;
  logic [3:0] wr_left;
  logic       accept;

  assign beats     = `SDCD_BEATS_BASE << BURST_CODE;
  assign REQ_READY = (gap == 8'h0);
  assign accept    = REQ_VALID && REQ_READY;
  assign WR_TAKE   = (wr_left != 4'h0);

  // pins are registered so the device sees them stable across its edge
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LNK.cs_n  <= 1'b1;
      LNK.we_n  <= 1'b1;
      LNK.ref_n <= 1'b1;
      LNK.addr  <= '0;
      LNK.ba    <= '0;
    end else begin
      LNK.addr <= REQ_ADDR;
      LNK.ba   <= REQ_BA;
      LNK.cs_n <= !(accept && REQ_CMD != idle_cmd);
      case (REQ_CMD)
        mode_set_cmd: {LNK.we_n, LNK.ref_n} <= 2'h0;
        write_cmd:    {LNK.we_n, LNK.ref_n} <= 2'h1;
        refresh_cmd:  {LNK.we_n, LNK.ref_n} <= 2'h2;
        default:      {LNK.we_n, LNK.ref_n} <= 2'h3;
      endcase
    end
  end

  // spacing: bursts drain before the next command, mode set waits its gap
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap <= 8'h0;
    end else if (accept) begin
      case (REQ_CMD)
        read_cmd:     gap <= 8'(beats) + TAIL;
        write_cmd:    gap <= 8'(beats) + TAIL;
        mode_set_cmd: gap <= GAP_CYC;
        default:      gap <= 8'h0;
      endcase
    end else if (gap != 8'h0) begin
      gap <= gap - 8'h1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_left             <= 4'h0;
      LNK.dq_host_o       <= '0;
      LNK.dq_host_oe      <= 1'b0;
      LNK.byte_write_mask <= '0;
    end else begin
      LNK.dq_host_oe      <= WR_TAKE;
      LNK.dq_host_o       <= WR_TAKE ? WR_DATA : '0;
      LNK.byte_write_mask <= WR_TAKE ? WR_MASK : '0;
      if (accept && REQ_CMD == write_cmd) begin
        wr_left <= beats;
      end else if (WR_TAKE) begin
        wr_left <= wr_left - 4'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= '0;
    end else begin
      RD_VALID <= LNK.dq_dev_oe;
      if (LNK.dq_dev_oe) begin
        RD_DATA <= LNK.dq;
      end
    end
  end
endmodule : sdcd_host

// ==== tb/sdcd_chk_sva.sv ====
module sdcd_chk (
  input wire logic CLK,        // command clock
  input wire logic RSTN,       // async reset, low active
  input wire logic cs_n,       // chip select
  input wire logic we_n,       // write enable
  input wire logic ref_n,      // refresh strobe
  input wire logic dq_host_oe, // host drives dq
  input wire logic dq_dev_oe   // device drives dq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic ms = !cs_n && !we_n && !ref_n;
  wire logic rd = !cs_n && we_n && ref_n;
  wire logic wr = !cs_n && !we_n && ref_n;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  property p_gap; ms |=> cs_n [*8] ##1 cs_n [*4]; endproperty
  a_gap: assert property (p_gap) else $error("command inside mode set gap");
  property p_rd_gap; rd |=> cs_n [*4]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("command during read burst");
  property p_rd_oe; rd |-> ##[1:2] dq_dev_oe; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read gave no data");
  property p_wr_oe; wr |-> ##[0:1] dq_host_oe; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write sent no data");
  property p_clash; !(dq_dev_oe && dq_host_oe); endproperty
  a_clash: assert property (p_clash) else $error("both ends drive dq");
  property p_ms_quiet; ms |-> !dq_dev_oe && !dq_host_oe; endproperty
  a_ms_quiet: assert property (p_ms_quiet) else $error("mode set during burst");
  property p_oe_min; $rose(dq_dev_oe) |-> dq_dev_oe [*2]; endproperty
  a_oe_min: assert property (p_oe_min) else $error("read burst too short");
  property p_oe_max; dq_dev_oe [*8] |=> !dq_dev_oe; endproperty
  a_oe_max: assert property (p_oe_max) else $error("read burst too long");
  property p_host_min; $rose(dq_host_oe) |-> dq_host_oe [*2]; endproperty
  a_host_min: assert property (p_host_min) else $error("write burst too short");
  property p_dev_src; $rose(dq_dev_oe) |-> $past(rd) || $past(rd, 2); endproperty
  a_dev_src: assert property (p_dev_src) else $error("device drove without read");
  c_ms: cover property (ms);
  c_rd: cover property (rd);
  c_wr: cover property (wr);
  c_rf: cover property (!cs_n && we_n && !ref_n);
endmodule : sdcd_chk

// ==== tb/sdcd_bench.sv ====
module sdcd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdcd_pkg::*;
  logic CLK, RSTN, REQ_VALID, REQ_READY, WR_TAKE, RD_VALID, BUSY;
  sdcd_cmd_t REQ_CMD, LAST_CMD, last_exp;
  logic [19:0] REQ_ADDR, MODE_ZERO, MODE_ONE, MODE_TWO, ADDR_USED;
  logic [3:0] REQ_BA, MODE_SEL;
  logic [1:0] BURST_CODE, WR_MASK;
  logic [17:0] WR_DATA, RD_DATA;
  logic [15:0] WR_BANKS, REFRESH_BANKS, rf_seen;
  logic [17:0] wd[8], rq[$];
  logic [1:0] wm[8];
  int fail_count = 0, total_checks = 0;
  int busy_cycles = 0;
  sdcd_if lnk();
  sdcd_host u_sdcd_host (.CLK(CLK), .RSTN(RSTN), .LNK(lnk), .REQ_VALID(REQ_VALID),
    .REQ_CMD(REQ_CMD), .REQ_ADDR(REQ_ADDR), .REQ_BA(REQ_BA), .REQ_READY(REQ_READY),
    .BURST_CODE(BURST_CODE), .WR_DATA(WR_DATA), .WR_MASK(WR_MASK), .WR_TAKE(WR_TAKE),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID));
  sdcd_device u_sdcd_device (.CLK(CLK), .RSTN(RSTN), .LNK(lnk), .MODE_ZERO(MODE_ZERO),
    .MODE_ONE(MODE_ONE), .MODE_TWO(MODE_TWO), .MODE_SEL(MODE_SEL), .BUSY(BUSY),
    .ADDR_USED(ADDR_USED), .WR_BANKS(WR_BANKS), .REFRESH_BANKS(REFRESH_BANKS),
    .LAST_CMD(LAST_CMD));
  sdcd_chk u_sdcd_chk (.CLK(CLK), .RSTN(RSTN), .cs_n(lnk.cs_n), .we_n(lnk.we_n),
    .ref_n(lnk.ref_n), .dq_host_oe(lnk.dq_host_oe), .dq_dev_oe(lnk.dq_dev_oe));
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  // pulse outputs are latched here so the sequence can look later
  always @(posedge CLK) begin
    if (RD_VALID === 1'b1) rq.push_back(RD_DATA);
    if (REFRESH_BANKS !== 16'h0000) rf_seen <= REFRESH_BANKS;
    if (BUSY === 1'b1) busy_cycles++;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : step
  // holds the request until taken, feeds write beats as each is taken
  task xfer(input sdcd_cmd_t c, input logic [19:0] a, input logic [3:0] b, input int nb);
    int k, n;
    logic acc, r, t;
    k = 0;
    n = 0;
    acc = 0;
    REQ_CMD = c; REQ_ADDR = a; REQ_BA = b; REQ_VALID = 1;
    WR_DATA = wd[0]; WR_MASK = wm[0];
    while ((!acc || (c == write_cmd && k < nb)) && n < 200) begin
      r = REQ_READY && !acc;
      t = WR_TAKE;
      step(1);
      n++;
      if (r) begin
        acc = 1;
        REQ_VALID = 0;
      end
      if (t && c == write_cmd) begin
        k++;
        WR_DATA = wd[k % 8];
        WR_MASK = wm[k % 8];
      end
    end
    check("accepted", n < 200, 1);
    step(nb + 4);
    if (c != idle_cmd) last_exp = c;
    check("last_cmd", LAST_CMD, last_exp);
  endtask : xfer
  initial begin
    RSTN = 0; REQ_VALID = 0; REQ_CMD = idle_cmd; REQ_ADDR = '0; REQ_BA = '0;
    BURST_CODE = 2'h0; WR_DATA = '0; WR_MASK = '0; last_exp = idle_cmd;
    wm = '{default: 2'h0};
    wd = '{default: 18'h0};
    step(12);
    RSTN = 1;
    check("mode_zero_rst", MODE_ZERO, 0);
    xfer(mode_set_cmd, 20'h5a0c3, 4'h0, 0);
    xfer(mode_set_cmd, 20'h0a0c5, 4'h5, 0);
    check("mode_sel", MODE_SEL, 4'h5);
    xfer(mode_set_cmd, 20'h30000, 4'h2, 0);
    xfer(mode_set_cmd, 20'hfffff, 4'h3, 0);
    check("mode_zero", MODE_ZERO, 20'h5a0c3);
    check("mode_one", MODE_ONE, 20'h0a0c5);
    check("mode_two", MODE_TWO, 20'h30000);
    wd[0] = 18'h3a5a5; wd[1] = 18'h1c3c3;
    xfer(write_cmd, 20'h00003, 4'hb, 2);
    wd[0] = 18'h2ffff; wd[1] = 18'h0f00f; wm[0] = 2'h1; wm[1] = 2'h2;
    xfer(write_cmd, 20'h00003, 4'hb, 2);
    xfer(idle_cmd, 20'h00000, 4'h0, 0);
    rq.delete();
    xfer(read_cmd, 20'h00003, 4'hb, 2);
    check("rd_count", rq.size(), 2);
    check("rd_beat0", rq[0], {9'h17f, 9'h1a5});
    check("rd_beat1", rq[1], {9'h0e1, 9'h00f});
    wm = '{default: 2'h0};
    for (int i = 0; i < 3; i++) begin
      xfer(mode_set_cmd, 20'h30000 | (i << 3), 4'h2, 0);
      xfer(write_cmd, 20'h00000, 4'hf, 2);
      check("wr_bank_count", $countones(WR_BANKS), 1 << i);
      check("wr_bank_hit", WR_BANKS[4'hf >> i], 1);
    end
    xfer(mode_set_cmd, 20'h00000, 4'h2, 0);
    xfer(refresh_cmd, 20'h00030, 4'h6, 0);
    check("rf_single", rf_seen, 16'h0040);
    xfer(mode_set_cmd, 20'h00020, 4'h2, 0);
    xfer(refresh_cmd, 20'h00305, 4'h9, 0);
    check("rf_multi", rf_seen, 16'h0305);
    xfer(mode_set_cmd, 20'h0a1c5, 4'h1, 0);
    BURST_CODE = 2'h1;
    rq.delete();
    busy_cycles = 0;
    xfer(read_cmd, 20'hffff3, 4'h2, 4);
    check("addr_used", ADDR_USED, 20'h7fff3);
    check("rd_count_bl4", rq.size(), 4);
    check("busy_bl4", busy_cycles, 4);
    // longest burst exercises the upper read-length bound
    xfer(mode_set_cmd, 20'h0a2c5, 4'h1, 0);
    BURST_CODE = 2'h2;
    rq.delete();
    busy_cycles = 0;
    xfer(read_cmd, 20'hffff3, 4'h2, 8);
    check("addr_used_bl8", ADDR_USED, 20'h3fff3);
    check("rd_count_bl8", rq.size(), 8);
    check("busy_bl8", busy_cycles, 8);
    results();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    results();
  end
endmodule : sdcd_bench
